// *** slp_pkg.sv ***
package slp_pkg;

	// Frame geometry of the twelve-way interleaved frame
	localparam int NSTS = 12;
	localparam int FRAME_BYTES = 9720;
	localparam logic [3:0] STS_FIRST = 4'h0;
	localparam logic [3:0] STS_FEBE = 4'h2;
	localparam logic [3:0] STS_LAST = 4'(NSTS - 1);
	localparam logic [3:0] ROW_SDCC = 4'h2;
	localparam logic [3:0] ROW_PTR = 4'h3;
	localparam logic [3:0] ROW_B2 = 4'h4;
	localparam logic [3:0] ROW_LDCC0 = 4'h5;
	localparam logic [3:0] ROW_LDCC1 = 4'h7;
	localparam logic [3:0] ROW_GROW = 4'h8;
	localparam logic [3:0] ROW_LAST = 4'h8;
	localparam logic [3:0] ROW_WRAP = 4'h6;
	localparam logic [6:0] COL_A = 7'h00;
	localparam logic [6:0] COL_B = 7'h01;
	localparam logic [6:0] COL_C = 7'h02;
	localparam logic [6:0] SPE_COL = 7'h03;
	localparam logic [6:0] GRP_LAST = 7'h59;
	localparam logic [9:0] SPE_BYTES = 10'h057;

	// Pointer and overhead byte values
	localparam logic [9:0] PTR_MAX = 10'h30e;
	localparam logic [9:0] I_MASK = 10'h2aa;
	localparam logic [9:0] D_MASK = 10'h155;
	localparam logic [3:0] JMAJ = 4'h3;
	localparam logic [3:0] NDF_NORM = 4'h6;
	localparam logic [15:0] CONCAT_IND = 16'h93ff;
	localparam logic [7:0] H3_FILL = 8'h00;
	localparam logic [6:0] FEBE_MAX = 7'(8 * NSTS);

	// Timing and sizing
	localparam int FRAME_US = 125;
	localparam int CLK_MHZ = 100;
	localparam int FRAME_CYC = FRAME_US * CLK_MHZ;
	localparam int FIFO_DEPTH = 8;
	localparam int FIFO_HI = 6;
	localparam int FIFO_LO = 2;
	localparam int CNT_W = 16;

	typedef enum logic [1:0] {JST_NONE, JST_POS, JST_NEG} slp_jst_e;
	typedef enum logic [1:0] {OHK_SDCC, OHK_LDCC, OHK_EOW} slp_ohk_e;

	typedef struct packed {
		logic [3:0] row;
		logic [6:0] grp;
		logic [3:0] sts;
	} slp_pos_s;

	typedef struct packed {
		logic poh;
		logic [3:0] sts;
		logic [7:0] dat;
	} slp_pl_s;

	typedef struct packed {
		slp_ohk_e kind;
		logic [7:0] dat;
	} slp_oh_s;

	// Next byte position in interleave order
	function automatic slp_pos_s slp_pos_next(input slp_pos_s p);
		slp_pos_s n;
		n = p;
		n.sts = p.sts + 4'h1;
		if (p.sts == STS_LAST)
		begin
			n.sts = 4'h0;
			n.grp = (p.grp == GRP_LAST) ? 7'h00 : p.grp + 7'h01;
			if (p.grp == GRP_LAST)
				n.row = (p.row == ROW_LAST) ? 4'h0 : p.row + 4'h1;
		end
		return n;
	endfunction

	// Overhead slot match on row and column group
	function automatic logic slp_at(input slp_pos_s p, input logic [3:0] r,
		input logic [6:0] g);
		return p.row == r && p.grp == g;
	endfunction

	// Count of ones in a ten bit word
	function automatic logic [3:0] slp_ones(input logic [9:0] v);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < 10; i++)
			n = n + {3'h0, v[i]};
		return n;
	endfunction

	// Pointer after one justification, wrapping within range
	function automatic logic [9:0] slp_ptr_step(input logic [9:0] p,
		input slp_jst_e j);
		logic [9:0] n;
		n = p;
		if (j == JST_POS)
			n = (p == PTR_MAX) ? 10'h000 : p + 10'h001;
		else if (j == JST_NEG)
			n = (p == 10'h000) ? PTR_MAX : p - 10'h001;
		return n;
	endfunction

endpackage

// *** slp_fifo.sv ***
`timescale 1ns/1ns
module slp_fifo
#(
	parameter int W = 8,
	parameter int DEPTH = 8
)
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data,
	output logic [$clog2(DEPTH):0] level
);
	localparam int AW = $clog2(DEPTH);

	generate
		if (DEPTH < 2 || (1 << AW) != DEPTH)
			$error("slp_fifo depth must be a power of two");
	endgenerate

	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ix;
	logic [AW-1:0] rd_ix;

	// Handshakes and next fill level
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	wire [AW:0] next_level = level + (AW + 1)'(push) - (AW + 1)'(pop);
	assign out_data = mem[rd_ix];

	// Storage writes
	always_ff @(posedge mclk)
	begin
		if (push)
			mem[wr_ix] <= in_data;
	end

	// Pointers and registered full/empty flags
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			wr_ix <= '0;
			rd_ix <= '0;
			level <= '0;
			in_ready <= 1'b1;
			out_valid <= 1'b0;
		end
		else
		begin
			wr_ix <= wr_ix + AW'(push);
			rd_ix <= rd_ix + AW'(pop);
			level <= next_level;
			in_ready <= next_level != (AW + 1)'(DEPTH);
			out_valid <= next_level != '0;
		end
	end

endmodule

// *** slp_bip8.sv ***
`timescale 1ns/1ns
module slp_bip8
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic en,
	input wire logic sof,
	input wire logic [7:0] dat,
	output logic [7:0] par,
	output logic par_ok
);
	logic [7:0] acc;
	logic seen;

	// Even parity per bit lane, closed at each frame start
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			acc <= 8'h00;
			par <= 8'h00;
			par_ok <= 1'b0;
			seen <= 1'b0;
		end
		else if (en && sof)
		begin
			par <= acc;
			par_ok <= seen;
			seen <= 1'b1;
			acc <= dat;
		end
		else if (en)
			acc <= acc ^ dat;
	end

endmodule

// *** slp_line_oh.sv ***
`timescale 1ns/1ns
module slp_line_oh
	import slp_pkg::*;
#(
	parameter int FRAME_CYC = slp_pkg::FRAME_CYC,
	parameter int FIFO_DEPTH = slp_pkg::FIFO_DEPTH,
	parameter int CNT_W = slp_pkg::CNT_W
)
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic concat,
	input wire logic tx_pl_valid,
	output logic tx_pl_ready,
	input wire logic [7:0] tx_pl_data,
	input wire logic [15:0] tx_aps,
	input wire logic [7:0] tx_sdcc,
	input wire logic [7:0] tx_ldcc,
	input wire logic [7:0] tx_eow,
	output slp_pkg::slp_oh_s tx_take,
	output logic tx_take_vld,
	input wire logic [7:0] tx_scr_fb,
	output logic [7:0] tx_byte,
	output logic tx_vld,
	output logic tx_fs,
	output logic tx_undr,
	input wire logic rx_en,
	input wire logic rx_fs,
	input wire logic [7:0] rx_dat,
	input wire logic [7:0] rx_scr,
	output slp_pkg::slp_pl_s rx_pl,
	output logic rx_pl_vld,
	output slp_pkg::slp_oh_s rx_oh,
	output logic rx_oh_vld,
	output logic [15:0] rx_aps,
	output logic [6:0] rx_febe,
	output logic rx_b2_err,
	output logic [CNT_W-1:0] rx_b2_cnt
);
	import slp_pkg::*;

	generate
		if (FRAME_CYC <= FRAME_BYTES || FRAME_CYC > 65535)
			$error("slp_line_oh frame cycle count out of range");
		if (FIFO_DEPTH <= FIFO_HI || CNT_W < 4)
			$error("slp_line_oh fifo depth or counter width too small");
	endgenerate

	localparam int LW = $clog2(FIFO_DEPTH) + 1;

	// Byte rate divider: FRAME_BYTES strobes in every FRAME_CYC cycles
	logic [15:0] ben_acc;
	logic tx_en;
	wire [16:0] ben_sum = {1'b0, ben_acc} + 17'(FRAME_BYTES);
	wire ben_hit = ben_sum >= 17'(FRAME_CYC);

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			ben_acc <= 16'h0000;
			tx_en <= 1'b0;
		end
		else
		begin
			tx_en <= ben_hit;
			ben_acc <= ben_hit ? 16'(ben_sum - 17'(FRAME_CYC)) : ben_sum[15:0];
		end
	end

	// Transmit payload buffer
	logic f_ovalid;
	logic f_pop;
	logic [7:0] f_odata;
	logic [LW-1:0] f_level;

	slp_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.in_valid(tx_pl_valid),
		.in_ready(tx_pl_ready),
		.in_data(tx_pl_data),
		.out_valid(f_ovalid),
		.out_ready(f_pop),
		.out_data(f_odata),
		.level(f_level)
	);

	// Transmit line parity over the scrambled bytes returned
	logic [7:0] tx_par;

	slp_bip8 u_tx_bip (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.en(tx_vld),
		.sof(tx_fs),
		.dat(tx_scr_fb),
		.par(tx_par),
		.par_ok()
	);

	// Transmit position decode
	slp_pos_s tx_pos;
	logic [9:0] tx_ptr;
	slp_jst_e tx_jst;
	logic [6:0] tx_febe_v;
	wire t_first = tx_pos.sts == STS_FIRST;
	wire t_oh = tx_pos.grp < SPE_COL;
	wire t_sof = tx_pos == '0;
	wire t_eof = tx_pos.row == ROW_LAST && tx_pos.grp == GRP_LAST
		&& tx_pos.sts == STS_LAST;
	wire t_h1 = slp_at(tx_pos, ROW_PTR, COL_A);
	wire t_h2 = slp_at(tx_pos, ROW_PTR, COL_B);
	wire t_h3 = slp_at(tx_pos, ROW_PTR, COL_C);
	wire t_b2 = slp_at(tx_pos, ROW_B2, COL_A);
	wire t_k1 = slp_at(tx_pos, ROW_B2, COL_B) && t_first;
	wire t_k2 = slp_at(tx_pos, ROW_B2, COL_C) && t_first;
	wire t_z2 = slp_at(tx_pos, ROW_GROW, COL_B) && tx_pos.sts == STS_FEBE;
	wire t_e2 = slp_at(tx_pos, ROW_GROW, COL_C) && t_first;
	wire t_sdcc = tx_pos.row == ROW_SDCC && t_oh && t_first;
	wire t_ldcc = tx_pos.row >= ROW_LDCC0 && tx_pos.row <= ROW_LDCC1
		&& t_oh && t_first;
	wire t_ohin = t_sdcc || t_ldcc || t_e2;
	wire t_stuff = tx_pos.row == ROW_PTR && tx_pos.grp == SPE_COL
		&& tx_jst == JST_POS;
	wire t_want = (!t_oh && !t_stuff) || (t_h3 && tx_jst == JST_NEG);
	assign f_pop = tx_en && t_want;

	// Pointer word with I or D bits inverted in a justification frame
	wire [9:0] t_inv = (tx_jst == JST_POS) ? I_MASK :
		(tx_jst == JST_NEG) ? D_MASK : 10'h000;
	wire [15:0] t_ptrw = (concat && !t_first) ? CONCAT_IND :
		{NDF_NORM, 2'b00, tx_ptr ^ t_inv};
	wire [7:0] t_ohdat = t_sdcc ? tx_sdcc : t_ldcc ? tx_ldcc : tx_eow;
	wire slp_ohk_e t_ohk = t_sdcc ? OHK_SDCC : t_ldcc ? OHK_LDCC : OHK_EOW;
	wire slp_jst_e next_jst = (f_level >= LW'(FIFO_HI)) ? JST_NEG :
		(f_level <= LW'(FIFO_LO)) ? JST_POS : JST_NONE;

	// Outgoing byte selection
	wire [7:0] t_byte =
		t_h1 ? t_ptrw[15:8] :
		t_h2 ? t_ptrw[7:0] :
		t_b2 ? (t_first ? tx_par : 8'h00) :
		t_k1 ? tx_aps[15:8] :
		t_k2 ? tx_aps[7:0] :
		t_z2 ? {1'b0, tx_febe_v} :
		t_ohin ? t_ohdat :
		t_want ? (f_ovalid ? f_odata : 8'h00) :
		t_h3 ? H3_FILL :
		8'h00;

	// Transmit frame counters, justification and output register
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			tx_pos <= '0;
			tx_ptr <= 10'h000;
			tx_jst <= JST_NONE;
			tx_byte <= 8'h00;
		end
		else if (tx_en)
		begin
			tx_pos <= slp_pos_next(tx_pos);
			tx_byte <= t_byte;
			if (t_sof)
				tx_jst <= next_jst;
			if (t_eof)
				tx_ptr <= slp_ptr_step(tx_ptr, tx_jst);
		end
	end

	// Transmit strobes and overhead take acknowledgement
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			tx_vld <= 1'b0;
			tx_fs <= 1'b0;
			tx_undr <= 1'b0;
			tx_take_vld <= 1'b0;
			tx_take <= '0;
		end
		else
		begin
			tx_vld <= tx_en;
			tx_fs <= tx_en && t_sof;
			tx_undr <= tx_en && t_want && !f_ovalid;
			tx_take_vld <= tx_en && t_ohin;
			if (tx_en && t_ohin)
				tx_take <= '{kind: t_ohk, dat: t_ohdat};
		end
	end

	// Receive line parity over the scrambled line bytes
	logic [7:0] rx_par;
	logic rx_par_ok;

	slp_bip8 u_rx_bip (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.en(rx_en),
		.sof(rx_fs),
		.dat(rx_scr),
		.par(rx_par),
		.par_ok(rx_par_ok)
	);

	// Receive position and per-STS pointer state
	slp_pos_s rx_pos;
	logic [9:0] ptr_mem [NSTS];
	slp_jst_e jst_mem [NSTS];
	logic [7:0] h1_hold [NSTS];
	logic [7:0] k1_hold;
	wire slp_pos_s rp = rx_fs ? '0 : rx_pos;
	wire r_first = rp.sts == STS_FIRST;
	wire [3:0] r_ix = concat ? STS_FIRST : rp.sts;
	wire r_own = !concat || r_first;
	wire r_oh = rp.grp < SPE_COL;
	wire r_h1 = slp_at(rp, ROW_PTR, COL_A);
	wire r_h2 = slp_at(rp, ROW_PTR, COL_B);
	wire r_h3 = slp_at(rp, ROW_PTR, COL_C);
	wire r_b2 = slp_at(rp, ROW_B2, COL_A) && r_first;
	wire r_k1 = slp_at(rp, ROW_B2, COL_B) && r_first;
	wire r_k2 = slp_at(rp, ROW_B2, COL_C) && r_first;
	wire r_z2 = slp_at(rp, ROW_GROW, COL_B) && rp.sts == STS_FEBE;
	wire r_e2 = slp_at(rp, ROW_GROW, COL_C) && r_first;
	wire r_sdcc = rp.row == ROW_SDCC && r_oh && r_first;
	wire r_ldcc = rp.row >= ROW_LDCC0 && rp.row <= ROW_LDCC1
		&& r_oh && r_first;

	// Pointer interpretation: majority of inverted I or D bits
	wire [9:0] r_new = {h1_hold[rp.sts][1:0], rx_dat};
	wire [9:0] r_old = ptr_mem[r_ix];
	wire [3:0] r_ni = slp_ones((r_new ^ r_old) & I_MASK);
	wire [3:0] r_nd = slp_ones((r_new ^ r_old) & D_MASK);
	wire slp_jst_e r_jst = (r_ni >= JMAJ) ? JST_POS :
		(r_nd >= JMAJ) ? JST_NEG : JST_NONE;
	wire slp_jst_e r_jcur = jst_mem[r_ix];

	// Payload, stuffing and path overhead start
	wire [3:0] r_roff = (rp.row >= ROW_PTR) ? rp.row - ROW_PTR :
		rp.row + ROW_WRAP;
	wire [9:0] r_off = 10'(r_roff * SPE_BYTES) + 10'(rp.grp - SPE_COL);
	wire r_stuff = rp.row == ROW_PTR && rp.grp == SPE_COL
		&& r_jcur == JST_POS;
	wire r_data = (!r_oh && !r_stuff)
		|| (r_h3 && r_jcur == JST_NEG);
	wire r_poh = !r_oh && r_own && r_off == r_old;

	// Parity compare and saturating error count
	wire [3:0] r_errs = slp_ones({2'b00, rx_dat ^ rx_par});
	wire r_chk = rx_en && r_b2 && rx_par_ok;
	wire [CNT_W:0] r_sum = {1'b0, rx_b2_cnt} + (CNT_W + 1)'(r_errs);

	// Receive counters and pointer tracking
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			rx_pos <= '0;
			for (int i = 0; i < NSTS; i++)
			begin
				ptr_mem[i] <= 10'h000;
				jst_mem[i] <= JST_NONE;
				h1_hold[i] <= 8'h00;
			end
		end
		else if (rx_en)
		begin
			rx_pos <= slp_pos_next(rp);
			if (r_h1)
				h1_hold[rp.sts] <= rx_dat;
			if (r_h2 && r_own)
			begin
				jst_mem[r_ix] <= r_jst;
				if (r_jst != JST_NONE)
					ptr_mem[r_ix] <= slp_ptr_step(r_old, r_jst);
				else if (r_new <= PTR_MAX)
					ptr_mem[r_ix] <= r_new;
			end
		end
	end

	// Receive payload and overhead outputs
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			rx_pl <= '0;
			rx_pl_vld <= 1'b0;
			rx_oh <= '0;
			rx_oh_vld <= 1'b0;
		end
		else
		begin
			rx_pl_vld <= rx_en && r_data;
			rx_oh_vld <= rx_en && (r_sdcc || r_ldcc || r_e2);
			if (rx_en && r_data)
				rx_pl <= '{poh: r_poh, sts: rp.sts, dat: rx_dat};
			if (rx_en)
				rx_oh <= '{kind: r_sdcc ? OHK_SDCC : r_ldcc ? OHK_LDCC :
					OHK_EOW, dat: rx_dat};
		end
	end

	// Line error monitoring, protection bytes and far-end report
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			rx_b2_err <= 1'b0;
			rx_b2_cnt <= '0;
			tx_febe_v <= 7'h00;
			rx_febe <= 7'h00;
			rx_aps <= 16'h0000;
			k1_hold <= 8'h00;
		end
		else
		begin
			rx_b2_err <= r_chk && r_errs != 4'h0;
			if (r_chk)
				tx_febe_v <= {3'h0, r_errs};
			if (r_chk && r_errs != 4'h0)
				rx_b2_cnt <= r_sum[CNT_W] ? '1 : r_sum[CNT_W-1:0];
			if (rx_en && r_z2)
				rx_febe <= (rx_dat[6:0] > FEBE_MAX) ? 7'h00 : rx_dat[6:0];
			if (rx_en && r_k1)
				k1_hold <= rx_dat;
			if (rx_en && r_k2)
				rx_aps <= {k1_hold, rx_dat};
		end
	end

	// Frame period watch
	logic [15:0] fcyc;
	logic fseen;

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			fcyc <= 16'h0000;
			fseen <= 1'b0;
		end
		else
		begin
			fcyc <= tx_fs ? 16'h0001 : fcyc + 16'h0001;
			fseen <= fseen || tx_fs;
		end
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (sys_rst);

	a_frame_period: assert property (
		tx_fs && fseen |-> fcyc == 16'(FRAME_CYC))
		else $error("frame period not fixed");
	a_ptr_range: assert property (ptr_mem[0] <= PTR_MAX)
		else $error("pointer above 782");
	a_h3_fill: assert property (tx_en && t_h3 && tx_jst != JST_NEG
		|=> tx_byte == H3_FILL)
		else $error("H3 not zero fill");
	a_h3_data: assert property (tx_en && t_h3 && tx_jst == JST_NEG
		&& f_ovalid |=> tx_byte == $past(f_odata))
		else $error("H3 missing payload byte");
	a_b2_insert: assert property (tx_en && t_b2 && t_first
		|=> tx_byte == $past(tx_par))
		else $error("B2 not last frame parity");
	a_b2_other: assert property (tx_en && t_b2 && !t_first
		|=> tx_byte == 8'h00)
		else $error("B2 used outside first STS-1");
	a_err_flag: assert property (r_chk && rx_dat != rx_par
		|=> rx_b2_err && rx_b2_cnt != $past(rx_b2_cnt)
		|| rx_b2_cnt == '1)
		else $error("parity mismatch not counted");
	a_z2_place: assert property (tx_en && t_z2
		|=> tx_byte == {1'b0, $past(tx_febe_v)})
		else $error("Z2 report misplaced");
	a_z2_clip: assert property (rx_febe <= FEBE_MAX)
		else $error("received count above maximum");
	a_aps_first: assert property (rx_en && slp_at(rp, ROW_B2, COL_C)
		&& !r_first |=> $stable(rx_aps))
		else $error("APS taken from other STS-1");

endmodule

// *** slp_line_peer.sv ***
`timescale 1ns/1ns
// Remote line terminal: one frame per call, one byte per clock
module slp_line_peer
(
	input wire logic mclk,
	output logic rx_en,
	output logic rx_fs,
	output logic [7:0] rx_dat,
	output logic [7:0] rx_scr
);
	logic [7:0] par = 8'h00;

	// Idle lines at time zero
	initial
	begin
		rx_en = 1'b0;
		rx_fs = 1'b0;
		rx_dat = 8'h00;
		rx_scr = 8'h00;
	end

	// Slot content; other STS-1s carry decoys that must be ignored
	function automatic logic [7:0] slot(input int r, g, s,
		input logic [9:0] p, m, input logic [7:0] b2, z2,
		input logic [15:0] k, input logic cc);
		logic s0;
		int o;
		s0 = s == 0;
		o = ((r + 6) % 9) * 87 + g - 3;
		if (g >= 3)
			return (o == m && (!cc || s0)) ? 8'he7 : 8'(o) ^ 8'(s);
		case (r * 3 + g)
			6, 7, 8: return s0 ? 8'hd1 : 8'h99;
			9: return (cc && !s0) ? 8'h93 : {6'b011000, p[9:8]};
			10: return (cc && !s0) ? 8'hff : p[7:0];
			12: return s0 ? b2 : 8'ha5;
			13: return s0 ? k[15:8] : ~k[15:8];
			14: return s0 ? k[7:0] : ~k[7:0];
			15, 16, 17, 18, 19, 20, 21, 22, 23: return s0 ? 8'hd4 : 8'h99;
			25: return (s == 2) ? z2 : 8'h7e;
			26: return s0 ? 8'he2 : 8'h99;
			default: return 8'h00;
		endcase
	endfunction

	// Send a frame; msk spoils B2 only when a scenario asks for it
	task automatic send_frame(input logic [9:0] p, m, input logic [7:0] z2,
		input logic [7:0] msk, input logic [15:0] k, input logic cc);
		logic [7:0] b2;
		logic [7:0] v;
		b2 = par ^ msk;
		par = 8'h00;
		for (int r = 0; r < 9; r++)
			for (int g = 0; g < 90; g++)
				for (int s = 0; s < 12; s++)
				begin
					v = slot(r, g, s, p, m, b2, z2, k, cc);
					@(posedge mclk);
					rx_en <= 1'b1;
					rx_fs <= (r == 0 && g == 0 && s == 0);
					rx_dat <= v;
					rx_scr <= v;
					par = par ^ v;
				end
		@(posedge mclk);
		rx_en <= 1'b0;
		rx_fs <= 1'b0;
		rx_dat <= ~v;
		rx_scr <= ~v;
	endtask
endmodule

// *** slp_line_oh_tb.sv ***
`timescale 1ns/1ns
module slp_line_oh_tb;
	import slp_pkg::*;
	localparam int FCYC = 9800;
	localparam int LIMIT = 100000;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic concat = 1'b0;
	logic tx_pl_valid = 1'b0;
	logic [7:0] tx_pl_data = 8'h3c;
	logic [15:0] tx_aps = 16'h4455;
	logic [7:0] tx_sdcc = 8'h11;
	logic [7:0] tx_ldcc = 8'h22;
	logic [7:0] tx_eow = 8'h33;
	logic tx_pl_ready, tx_take_vld, tx_vld, tx_fs, tx_undr;
	logic rx_en, rx_fs, rx_pl_vld, rx_oh_vld, rx_b2_err, seen_full;
	logic [7:0] tx_scr_fb, tx_byte, rx_dat, rx_scr, par_run, par_prev;
	logic [7:0] b2_exp;
	logic [9:0] h_last, h_prev;
	slp_oh_s tx_take, rx_oh;
	slp_pl_s rx_pl;
	logic [15:0] rx_aps;
	logic [6:0] rx_febe;
	logic [CNT_W-1:0] rx_b2_cnt;
	logic [7:0] curf [FRAME_BYTES];
	logic [7:0] lastf [FRAME_BYTES];
	logic [7:0] ohd [4];
	int noh [4] = '{default: 0};
	int fail_count = 0;
	int checks_done = 0;
	int cyc = 0;
	int pos = 0;
	int nfr = 0;
	int fs_at = 0;
	int gap = 0;
	int nerr = 0;
	int npoh = 0;
	int nnz = 0;
	int nbad = 0;
	int nundr = 0;
	int ntake = 0;

	always #5 mclk = ~mclk;
	// Echo stands in for the zero-latency scrambler
	assign tx_scr_fb = tx_byte ^ 8'h5a;

	slp_line_oh #(.FRAME_CYC(FCYC)) i_slp_line_oh (.mclk(mclk),
		.sys_rst(sys_rst), .concat(concat), .tx_pl_valid(tx_pl_valid),
		.tx_pl_ready(tx_pl_ready), .tx_pl_data(tx_pl_data),
		.tx_aps(tx_aps), .tx_sdcc(tx_sdcc), .tx_ldcc(tx_ldcc),
		.tx_eow(tx_eow), .tx_take(tx_take), .tx_take_vld(tx_take_vld),
		.tx_scr_fb(tx_scr_fb), .tx_byte(tx_byte), .tx_vld(tx_vld),
		.tx_fs(tx_fs), .tx_undr(tx_undr), .rx_en(rx_en), .rx_fs(rx_fs),
		.rx_dat(rx_dat), .rx_scr(rx_scr), .rx_pl(rx_pl),
		.rx_pl_vld(rx_pl_vld), .rx_oh(rx_oh), .rx_oh_vld(rx_oh_vld),
		.rx_aps(rx_aps), .rx_febe(rx_febe), .rx_b2_err(rx_b2_err),
		.rx_b2_cnt(rx_b2_cnt));
	slp_line_peer i_slp_line_peer (.mclk(mclk), .rx_en(rx_en),
		.rx_fs(rx_fs), .rx_dat(rx_dat), .rx_scr(rx_scr));

	// Capture transmit frames, their parity and the hang limit
	initial
	begin
		seen_full = 1'b0;
		par_run = 8'h00;
		par_prev = 8'h00;
	end
	always @(posedge mclk)
	begin
		cyc++;
		if (!tx_pl_ready)
			seen_full = 1'b1;
		if (tx_undr)
			nundr++;
		if (tx_take_vld)
			ntake++;
		if (tx_vld && tx_fs)
		begin
			lastf = curf;
			gap = cyc - fs_at;
			fs_at = cyc;
			h_prev = h_last;
			h_last = {curf[3240][1:0], curf[3252]};
			b2_exp = par_prev;
			par_prev = par_run;
			par_run = 8'h00;
			pos = 0;
			nfr++;
		end
		if (tx_vld && pos < FRAME_BYTES)
		begin
			curf[pos] = tx_byte;
			par_run = par_run ^ tx_scr_fb;
			pos++;
		end
		if (cyc >= LIMIT)
		begin
			fail_count++;
			$display("[ERR] run time expected below %0d seen %0d", LIMIT, cyc);
			final_report();
		end
	end

	// Tally receive-side events
	always @(posedge mclk)
	begin
		if (rx_b2_err)
			nerr++;
		if (rx_pl_vld && rx_pl.poh)
		begin
			npoh++;
			nnz += (rx_pl.sts != 4'h0);
			nbad += (rx_pl.dat != 8'he7);
		end
		if (rx_oh_vld)
		begin
			noh[rx_oh.kind]++;
			ohd[rx_oh.kind] = rx_oh.dat;
		end
	end

	task automatic check(input string what, input logic [15:0] seen, exp);
		checks_done++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	function automatic int b(input int r, g, s);
		return r * 1080 + g * 12 + s;
	endfunction

	task automatic ticks(input int n);
		repeat (n) @(posedge mclk);
	endtask

	task automatic wait_frames(input int n);
		int t;
		t = nfr + n;
		while (nfr < t)
			@(posedge mclk);
	endtask

	task automatic do_reset();
		sys_rst <= 1'b1;
		ticks(5);
		sys_rst <= 1'b0;
		@(posedge mclk);
	endtask

	// Clean frames: decoy B2, channel counts, APS, FEBE and J1
	task automatic rx_good();
		int e0, p0, b0, s0, l0, d0;
		e0 = nerr;
		p0 = npoh;
		b0 = nbad;
		s0 = noh[0];
		l0 = noh[1];
		d0 = noh[2];
		repeat (2)
			i_slp_line_peer.send_frame(10'h064, 10'h064, 8'h2a, 8'h00,
				16'h1234, 1'b0);
		ticks(3);
		check("b2 errors", 16'(nerr - e0), 16'h0000);
		check("b2 count", rx_b2_cnt, 16'h0000);
		check("j1 count", 16'(npoh - p0), 16'h0018);
		check("j1 place", 16'(nbad - b0), 16'h0000);
		check("sdcc bytes", 16'(noh[0] - s0), 16'h0006);
		check("ldcc bytes", 16'(noh[1] - l0), 16'h0012);
		check("eow bytes", 16'(noh[2] - d0), 16'h0002);
		check("ldcc data", {8'h00, ohd[1]}, 16'h00d4);
		check("aps", rx_aps, 16'h1234);
		check("febe", {9'h000, rx_febe}, 16'h002a);
	endtask

	// Empty buffer: positive stuffing, overhead placement, parity
	task automatic tx_pos();
		logic [9:0] p;
		int u0, t0;
		wait_frames(1);
		u0 = nundr;
		t0 = ntake;
		wait_frames(1);
		p = h_prev ^ I_MASK;
		check("underrun", 16'(nundr - u0), 16'h24a8);
		check("take count", 16'(ntake - t0), 16'h000d);
		check("take last", {6'h00, tx_take}, {6'h00, OHK_EOW, 8'h33});
		check("tx b2", lastf[b(4, 0, 0)], b2_exp);
		check("b2 other", lastf[b(4, 0, 1)], 8'h00);
		check("h3 fill", lastf[b(3, 2, 0)], H3_FILL);
		check("k1", lastf[b(4, 1, 0)], 8'h44);
		check("k2", lastf[b(4, 2, 0)], 8'h55);
		check("k1 other", lastf[b(4, 1, 5)], 8'h00);
		check("d1", lastf[b(2, 0, 0)], 8'h11);
		check("d12", lastf[b(7, 2, 0)], 8'h22);
		check("e2", lastf[b(8, 2, 0)], 8'h33);
		check("e2 other", lastf[b(8, 2, 4)], 8'h00);
		check("z2", lastf[b(8, 1, 2)], 8'h00);
		check("frame gap", 16'(gap), 16'(FCYC));
		check("h1 flag", {10'h000, lastf[3240][7:2]}, 16'h0018);
		check("ptr up", h_last ^ I_MASK,
			(p == PTR_MAX) ? 10'h000 : p + 10'h001);
	endtask

	// Spoiled B2, FEBE range ends, pointer above range ignored
	task automatic rx_err();
		int e0, p0, b0;
		e0 = nerr;
		p0 = npoh;
		b0 = nbad;
		i_slp_line_peer.send_frame(10'h064, 10'h064, 8'he0, 8'h05,
			16'h1234, 1'b0);
		ticks(3);
		check("b2 err pulse", 16'(nerr - e0), 16'h0001);
		check("b2 count", rx_b2_cnt, 16'h0002);
		check("febe max", {9'h000, rx_febe}, 16'h0060);
		wait_frames(1);
		check("z2 sent", lastf[b(8, 1, 2)], 8'h02);
		i_slp_line_peer.send_frame(10'h364, 10'h064, 8'h7f, 8'h00,
			16'h1234, 1'b0);
		ticks(3);
		check("febe over", {9'h000, rx_febe}, 16'h0000);
		check("b2 count", rx_b2_cnt, 16'h0002);
		check("j1 kept", 16'(npoh - p0), 16'h0018);
		check("j1 place", 16'(nbad - b0), 16'h0000);
	endtask

	// Full buffer: negative stuffing puts data into H3
	task automatic tx_neg();
		logic [9:0] p;
		int u0;
		u0 = nundr;
		wait_frames(2);
		p = h_prev ^ D_MASK;
		check("no underrun", 16'(nundr - u0), 16'h0000);
		check("h3 data", lastf[b(3, 2, 0)], 8'h3c);
		check("h3 data last", lastf[b(3, 2, 11)], 8'h3c);
		check("ptr down", h_last ^ D_MASK,
			(p == 10'h000) ? PTR_MAX : p - 10'h001);
		check("frame gap", 16'(gap), 16'(FCYC));
		check("fifo full", {15'h0000, seen_full}, 16'h0001);
		check("z2 zero", lastf[b(8, 1, 2)], 8'h00);
	endtask

	// Concatenated mode: one path overhead, indicator pointers
	task automatic concat_mode();
		int p0, z0;
		concat <= 1'b1;
		do_reset();
		check("count reset", rx_b2_cnt, 16'h0000);
		p0 = npoh;
		z0 = nnz;
		i_slp_line_peer.send_frame(10'h032, 10'h032, 8'h00, 8'h00,
			16'h1234, 1'b1);
		ticks(3);
		check("poh first only", 16'(nnz - z0), 16'h0000);
		check("poh count", 16'(npoh - p0), 16'h0001);
		wait_frames(1);
		check("concat h1", lastf[b(3, 0, 7)], 8'h93);
		check("concat h2", lastf[b(3, 1, 7)], 8'hff);
	endtask

	// Main sequence
	initial
	begin
		do_reset();
		rx_good();
		tx_pos();
		tx_pl_valid <= 1'b1;
		rx_err();
		tx_neg();
		concat_mode();
		final_report();
	end
endmodule
